//--- design/flash_host.sv
// Host controller that runs unlock command sequences and polls a parallel flash
`timescale 1ns/1ps
module flash_host #(
  parameter int AW         = 19,
  parameter int POLL_LIMIT = flash_host_pkg::POLL_LIMIT
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          req,
  input  wire flash_host_pkg::op_t op,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [7:0]    req_data,
  output logic               busy,
  output logic               resp_valid,
  output logic [7:0]         resp_data,
  output logic               resp_timeout,
  output logic               chip_sel_n,
  output logic               out_gate_n,
  output logic               write_str_n,
  output logic [AW-1:0]      addr_o,
  output logic [7:0]         dq_o,
  output logic               dq_oe,
  input  wire logic [7:0]    dq_i
);
  localparam int PW = $clog2(POLL_LIMIT + 1);
  // Upper address bits must exist above the command field
  if (AW <= flash_host_pkg::CMD_ADDR_BITS || AW > 24 || POLL_LIMIT < 1) begin : g_bad_params
    $error("flash_host: unsupported parameters");
  end

  typedef enum logic [2:0] {S_IDLE, S_CMD, S_WAIT, S_POLL1, S_POLL2, S_DONE} host_st_t;

  // Pin input passes two flops before use
  logic [7:0] dq_s1_q, dq_s2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else if (ce) begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  host_st_t            st_q, st_d;
  flash_host_pkg::op_t op_q, op_d;
  logic [AW-1:0]       a_q, a_d;
  logic [7:0]          d_q, d_d, tog_q, tog_d, res_q, res_d;
  logic [2:0]          idx_q, idx_d;
  logic [PW-1:0]       poll_q, poll_d;
  logic                busy_q, busy_d, rv_q, rv_d, to_q, to_d;
  logic                cyc_start, cyc_wr, cyc_done;
  logic [AW-1:0]       cyc_addr;
  logic [7:0]          cyc_wdata, cyc_rdata;
  logic [2:0]          last_idx;
  logic                polls;

  // Sequence step table; only low fifteen address bits carry the command
  function automatic logic [22:0] step(input flash_host_pkg::op_t o, input logic [2:0] i);
    logic [14:0] a;
    logic [7:0]  d;
    a = flash_host_pkg::UNLOCK_ADDR_A;
    d = flash_host_pkg::UNLOCK_DATA_A;
    if (i == 3'd1 || i == 3'd4) begin
      a = flash_host_pkg::UNLOCK_ADDR_B;
      d = flash_host_pkg::UNLOCK_DATA_B;
    end else if (i == 3'd2) begin
      case (o)
        flash_host_pkg::OP_PROGRAM:      d = flash_host_pkg::CMD_PROGRAM;
        flash_host_pkg::OP_ID_ENTRY:     d = flash_host_pkg::CMD_ID_ENTRY;
        flash_host_pkg::OP_ID_EXIT_LONG: d = flash_host_pkg::CMD_ID_EXIT;
        default:                         d = flash_host_pkg::CMD_ERASE_SET;
      endcase
    end else if (i == 3'd5) begin
      d = (o == flash_host_pkg::OP_CHIP_ERASE) ? flash_host_pkg::CMD_CHIP_ER
                                               : flash_host_pkg::CMD_SECTOR_ER;
    end
    return {a, d};
  endfunction

  always_comb begin
    case (op_q)
      flash_host_pkg::OP_PROGRAM:       last_idx = 3'd3;
      flash_host_pkg::OP_SECTOR_ERASE,
      flash_host_pkg::OP_CHIP_ERASE:    last_idx = 3'd5;
      flash_host_pkg::OP_ID_EXIT_SHORT: last_idx = 3'd0;
      default:                          last_idx = 3'd2;
    endcase
  end

  assign polls = (op_q == flash_host_pkg::OP_PROGRAM) ||
                 (op_q == flash_host_pkg::OP_SECTOR_ERASE) ||
                 (op_q == flash_host_pkg::OP_CHIP_ERASE);

  always_comb begin
    logic [22:0] s;
    s = step(op_q, idx_q);
    cyc_addr  = {{(AW - 15){1'b0}}, s[22:8]};
    cyc_wdata = s[7:0];
    if (op_q == flash_host_pkg::OP_ID_EXIT_SHORT) begin
      cyc_wdata = flash_host_pkg::CMD_ID_EXIT;
    end else if (op_q == flash_host_pkg::OP_PROGRAM && idx_q == 3'd3) begin
      cyc_addr  = a_q;
      cyc_wdata = d_q;
    end else if (op_q == flash_host_pkg::OP_SECTOR_ERASE && idx_q == 3'd5) begin
      cyc_addr = {a_q[AW-1:flash_host_pkg::SECTOR_LSB],
                  {flash_host_pkg::SECTOR_LSB{1'b0}}};
    end
    if (st_q == S_POLL1 || st_q == S_POLL2 || op_q == flash_host_pkg::OP_READ) begin
      cyc_addr = a_q;
    end
  end

  always_comb begin
    st_d = st_q; op_d = op_q; a_d = a_q; d_d = d_q; idx_d = idx_q;
    tog_d = tog_q; res_d = res_q; poll_d = poll_q; busy_d = busy_q;
    rv_d = 1'b0; to_d = to_q;
    cyc_start = 1'b0;
    cyc_wr = 1'b1;
    case (st_q)
      S_IDLE: begin
        // New requests only while idle, so nothing lands mid-operation
        if (req) begin
          op_d = op; a_d = req_addr; d_d = req_data; idx_d = 3'd0;
          busy_d = 1'b1; to_d = 1'b0; poll_d = '0;
          st_d = S_CMD;
        end
      end
      S_CMD: begin
        // Every step is issued exactly, so the device never aborts
        cyc_start = 1'b1;
        cyc_wr = (op_q != flash_host_pkg::OP_READ);
        st_d = S_WAIT;
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (op_q == flash_host_pkg::OP_READ) begin
            res_d = cyc_rdata; st_d = S_DONE;
          end else if (idx_q != last_idx) begin
            idx_d = idx_q + 3'd1; st_d = S_CMD;
          end else if (polls) begin
            st_d = S_POLL1; cyc_start = 1'b0;
          end else begin
            st_d = S_DONE;
          end
        end
      end
      S_POLL1: begin
        cyc_start = 1'b1; cyc_wr = 1'b0;
        st_d = S_POLL2;
      end
      S_POLL2: begin
        if (cyc_done) begin
          tog_d = cyc_rdata;
          poll_d = poll_q + PW'(1);
          res_d = cyc_rdata;
          // Two reads agreeing on the toggle bit means the write ended
          if (poll_q != '0 && cyc_rdata[6] == tog_q[6]) begin
            st_d = S_DONE;
          end else if (poll_q == PW'(POLL_LIMIT)) begin
            to_d = 1'b1; st_d = S_DONE;
          end else begin
            st_d = S_POLL1;
          end
        end
      end
      S_DONE: begin
        rv_d = 1'b1; busy_d = 1'b0; st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE; op_q <= flash_host_pkg::OP_READ; a_q <= '0; d_q <= 8'h00;
      idx_q <= 3'd0; tog_q <= 8'h00; res_q <= 8'h00; poll_q <= '0;
      busy_q <= 1'b0; rv_q <= 1'b0; to_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d; op_q <= op_d; a_q <= a_d; d_q <= d_d;
      idx_q <= idx_d; tog_q <= tog_d; res_q <= res_d; poll_q <= poll_d;
      busy_q <= busy_d; rv_q <= rv_d; to_q <= to_d;
    end
  end

  // Chip select idles high so the device stays in standby
  flash_bus_cycle #(.AW(AW)) u_cycle (
    .clk         (clk),
    .rstn        (rstn),
    .ce          (ce),
    .start       (cyc_start),
    .is_write    (cyc_wr),
    .addr        (cyc_addr),
    .wdata       (cyc_wdata),
    .dq_sync     (dq_s2_q),
    .done        (cyc_done),
    .rdata       (cyc_rdata),
    .chip_sel_n  (chip_sel_n),
    .out_gate_n  (out_gate_n),
    .write_str_n (write_str_n),
    .addr_o      (addr_o),
    .dq_o        (dq_o),
    .dq_oe       (dq_oe)
  );

  assign busy         = busy_q;
  assign resp_valid   = rv_q;
  assign resp_data    = res_q;
  assign resp_timeout = to_q;
endmodule // flash_host

//--- design/flash_host_pkg.sv
// Package: command codes, unlock addresses and bus timing for the flash host
package flash_host_pkg;
  localparam logic [14:0] UNLOCK_ADDR_A  = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_B  = 15'h2AAA;
  localparam logic [7:0]  UNLOCK_DATA_A  = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA_B  = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0]  CMD_SECTOR_ER  = 8'h30;
  localparam logic [7:0]  CMD_CHIP_ER    = 8'h10;
  localparam logic [7:0]  CMD_ID_ENTRY   = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT    = 8'hF0;
  localparam logic [14:0] ID_MAKER_ADDR  = 15'h0000;
  localparam logic [14:0] ID_PART_ADDR   = 15'h0001;
  localparam int          SECTOR_LSB     = 12;
  localparam int          CMD_ADDR_BITS  = 15;
  // Strobe low time, well above the 5 ns glitch filter
  localparam int          CLK_NS         = 100;
  localparam int          GLITCH_NS      = 5;
  localparam int          STROBE_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int          READ_CYC       = 2;
  localparam int          POLL_LIMIT     = 1000000;
  typedef enum logic [2:0] {
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_ID_ENTRY,
    OP_ID_EXIT_SHORT,
    OP_ID_EXIT_LONG,
    OP_READ
  } op_t;
endpackage

//--- design/flash_bus_cycle.sv
// One flash bus cycle: a glitch-free write strobe or a read with data capture
`timescale 1ns/1ps
module flash_bus_cycle #(
  parameter int AW = 19
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  input  wire logic [7:0]    dq_sync,
  output logic               done,
  output logic [7:0]         rdata,
  output logic               chip_sel_n,
  output logic               out_gate_n,
  output logic               write_str_n,
  output logic [AW-1:0]      addr_o,
  output logic [7:0]         dq_o,
  output logic               dq_oe
);
  localparam int CW = 8;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_ACTIVE, C_HOLD} cyc_t;
  if (flash_host_pkg::STROBE_CYC < 1 || flash_host_pkg::READ_CYC + 2 > 255) begin : g_bad_counts
    $error("flash_bus_cycle: bad cycle counts");
  end
  cyc_t          st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          wr_q, wr_d, done_q, done_d;
  logic          cs_q, cs_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic [AW-1:0] a_q, a_d;
  logic [7:0]    do_q, do_d, rd_q, rd_d;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; done_d = 1'b0;
    cs_d = cs_q; oe_d = oe_q; we_d = we_q; dqoe_d = dqoe_q;
    a_d = a_q; do_d = do_q; rd_d = rd_q;
    case (st_q)
      C_IDLE: begin
        if (start) begin
          // Address and data settle while all strobes are high
          st_d = C_SETUP; wr_d = is_write; a_d = addr; do_d = wdata;
          dqoe_d = is_write;
        end
      end
      C_SETUP: begin
        // Write keeps the output gate high so nothing is inhibited
        cs_d = 1'b0; we_d = !wr_q; oe_d = wr_q;
        cnt_d = wr_q ? CW'(flash_host_pkg::STROBE_CYC) : CW'(flash_host_pkg::READ_CYC);
        st_d = C_ACTIVE;
      end
      C_ACTIVE: begin
        if (cnt_q > CW'(1)) begin
          cnt_d = cnt_q - CW'(1);
        end else begin
          cs_d = 1'b1; we_d = 1'b1; oe_d = 1'b1;
          st_d = C_HOLD;
        end
      end
      C_HOLD: begin
        // Synchroniser lags two clocks, so this is what stood with the gate low
        rd_d = dq_sync;
        dqoe_d = 1'b0; done_d = 1'b1; st_d = C_IDLE;
      end
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= C_IDLE; cnt_q <= '0; wr_q <= 1'b0; done_q <= 1'b0;
      cs_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1; dqoe_q <= 1'b0;
      a_q <= '0; do_q <= 8'h00; rd_q <= 8'h00;
    end else if (ce) begin
      st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; done_q <= done_d;
      cs_q <= cs_d; oe_q <= oe_d; we_q <= we_d; dqoe_q <= dqoe_d;
      a_q <= a_d; do_q <= do_d; rd_q <= rd_d;
    end
  end

  assign done        = done_q;
  assign rdata       = rd_q;
  assign chip_sel_n  = cs_q;
  assign out_gate_n  = oe_q;
  assign write_str_n = we_q;
  assign addr_o      = a_q;
  assign dq_o        = do_q;
  assign dq_oe       = dqoe_q;
endmodule // flash_bus_cycle

//--- verification/flash_host_props.sv
// Pin protocol checks on the flash host controller
`timescale 1ns/1ps
module flash_host_props #(
  parameter int AW         = 19,
  parameter int POLL_LIMIT = 20
) (
  input wire logic          clk,
  input wire logic          rstn,
  input wire logic          req,
  input wire logic          busy,
  input wire logic          resp_valid,
  input wire logic          chip_sel_n,
  input wire logic          out_gate_n,
  input wire logic          write_str_n,
  input wire logic [AW-1:0] addr_o,
  input wire logic [7:0]    dq_o,
  input wire logic          dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_no_contend:
    assert property (!out_gate_n |-> !dq_oe) else $error("Host drives data in a read");
  chk_strobe_excl:
    assert property (!(!out_gate_n && !write_str_n)) else $error("Gate and strobe both low");
  chk_write_data:
    assert property (!write_str_n |-> dq_oe && $stable(addr_o) && $stable(dq_o))
      else $error("Write data or address moved");
  chk_strobe_width:
    assert property ($fell(write_str_n) |-> (!write_str_n && !chip_sel_n)[*2] ##1 write_str_n)
      else $error("Write strobe width wrong");
  chk_read_width:
    assert property ($fell(out_gate_n) |-> (!out_gate_n && !chip_sel_n)[*2] ##1 out_gate_n)
      else $error("Read gate width wrong");
  chk_data_hold:
    assert property ($rose(write_str_n) |-> dq_oe ##1 !dq_oe) else $error("Data hold wrong");
  chk_sel_idle:
    assert property (!chip_sel_n |-> busy) else $error("Device selected while idle");
  chk_resp_pulse:
    assert property (resp_valid |=> !resp_valid && !busy) else $error("Response not a pulse");
  chk_req_taken:
    assert property (req && !busy |-> ##[1:2] busy) else $error("Request not taken");
endmodule // flash_host_props

bind flash_host flash_host_props #(.AW(AW), .POLL_LIMIT(POLL_LIMIT)) props (
  .clk(clk), .rstn(rstn), .req(req), .busy(busy), .resp_valid(resp_valid),
  .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_str_n(write_str_n),
  .addr_o(addr_o), .dq_o(dq_o), .dq_oe(dq_oe)
);

//--- verification/flash_dev_model.sv
// Behavioural byte-wide flash with unlock sequences and status polling
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int         AW         = 19,
  parameter int         BUSY_READS = 4,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h4D  // Arbitrary value
) (
  input  wire logic          chip_sel_n,
  input  wire logic          out_gate_n,
  input  wire logic          write_str_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    dq_in,
  input  wire logic          stuck,
  output logic [7:0]         dq_out,
  output logic               dq_drv
);
  logic [7:0]     mem [256];
  logic [7:0]     prog_q = 8'h00;
  logic [AW-13:0] sect_q = '0;
  logic           tog = 1'b0;
  logic           id_mode = 1'b0;
  logic           erase = 1'b0;
  int             step = 0;
  int             busy = 0;
  realtime        t_fall = 0;
  wire            wr_n = chip_sel_n | write_str_n;
  wire            rd_n = chip_sel_n | out_gate_n | ~write_str_n;
  initial begin
    dq_out = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Only the low address byte is stored, enough for the bench
  task automatic decode(input logic [AW-1:0] a, input logic [7:0] d);
    logic [14:0] c;
    c = a[14:0];
    if (d == 8'hF0 && (step == 0 || step == 2 && c == 15'h5555)) begin
      id_mode = 1'b0;
      step = 0;
    end else begin
      case (step)
        0, 4: step = (c == 15'h5555 && d == 8'hAA) ? step + 1 : 0;
        1, 5: step = (c == 15'h2AAA && d == 8'h55) ? step + 1 : 0;
        2: begin
          if (c == 15'h5555 && d == 8'h90) id_mode = 1'b1;
          step = (c != 15'h5555) ? 0 : (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
        end
        3: begin
          mem[a[7:0]] = d;
          prog_q = d;
          erase = 1'b0;
          busy = BUSY_READS;
          step = 0;
        end
        default: begin
          if (d == 8'h30 || c == 15'h5555 && d == 8'h10) begin
            if (d == 8'h30) sect_q = a[AW-1:12];
            foreach (mem[i]) mem[i] = 8'hFF;
            erase = 1'b1;
            busy = BUSY_READS;
          end
          step = 0;
        end
      endcase
    end
  endtask
  always @(negedge wr_n) t_fall = $realtime;
  always @(posedge wr_n) begin
    if (out_gate_n && $realtime - t_fall >= 5.0 && busy == 0) begin
      decode(addr, dq_in);
    end
  end
  always @(negedge rd_n) begin
    if (busy > 0) begin
      tog = ~tog;
      if (!stuck) busy--;
      dq_out = {erase ? 1'b0 : ~prog_q[7], tog, 6'h15};
    end else if (id_mode && addr[AW-1:1] == '0) begin
      dq_out = addr[0] ? PART_CODE : MAKER_CODE;
    end else begin
      dq_out = mem[addr[7:0]];
    end
  end
  // Released bus flips so a stale value can never pass as a read
  always @(posedge rd_n) dq_out = ~dq_out;
  assign dq_drv = ~rd_n;
endmodule // flash_dev_model

//--- verification/tb_top.sv
// Self-checking bench: flash host controller against the flash model
`timescale 1ns/1ps
module tb_top;
  localparam int         AW    = 19;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART  = 8'h4D; // Arbitrary value
  logic                clk, rstn, req, busy, resp_valid, resp_timeout, stuck;
  logic                chip_sel_n, out_gate_n, write_str_n, dq_oe, dq_drv;
  flash_host_pkg::op_t op;
  logic [AW-1:0]       req_addr, addr_o, a;
  logic [7:0]          req_data, resp_data, dq_o, dq_out, dq_bus, d;
  logic [8:0]          expq[$];
  logic [8:0]          e;
  int                  errors, n_compared, seed;
  assign dq_bus = dq_oe ? dq_o : dq_out;
  flash_host #(.AW(AW), .POLL_LIMIT(20)) dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .req(req), .op(op), .req_addr(req_addr),
    .req_data(req_data), .busy(busy), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_timeout(resp_timeout), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .write_str_n(write_str_n), .addr_o(addr_o), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_bus)
  );
  flash_dev_model #(.AW(AW), .MAKER_CODE(MAKER), .PART_CODE(PART)) flash (
    .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_str_n(write_str_n),
    .addr(addr_o), .dq_in(dq_bus), .stuck(stuck), .dq_out(dq_out), .dq_drv(dq_drv)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] ex);
    n_compared++;
    if (got !== ex) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Busy is given two edges to rise, so a slow start cannot end the wait early
  task automatic do_op(input flash_host_pkg::op_t o, input logic [AW-1:0] ad,
                       input logic chk, input logic [7:0] ex);
    int n;
    expq.push_back({chk, ex});
    @(negedge clk);
    op = o;
    req_addr = (o == flash_host_pkg::OP_SECTOR_ERASE) ? {ad[AW-1:12], 12'h000} : ad;
    req_data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    @(negedge clk);
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge clk);
    if (busy !== 1'b0) begin
      errors++;
      $display("CHECK FAILED t=%0t operation never finished", $time);
    end
  endtask
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (dq_drv === 1'b1 && dq_oe === 1'b1) begin
      errors++;
      $display("CHECK FAILED t=%0t host and flash both drive data", $time);
    end
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("CHECK FAILED t=%0t unexpected response", $time);
      end else begin
        e = expq.pop_front();
        if (e[8]) check(resp_data, e[7:0]);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED t=%0t run timed out", $time);
    test_done();
  end
  initial begin
    seed = 32'hFCF7514F;
    {rstn, req, stuck} = 3'h0;
    op = flash_host_pkg::OP_READ;
    req_addr = '0;
    req_data = 8'h00;
    d = 8'h00;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    do_op(flash_host_pkg::OP_READ, 19'h00000, 1'b1, 8'hFF);
    repeat (4) begin
      a = AW'($random(seed));
      d = 8'($random(seed));
      do_op(flash_host_pkg::OP_PROGRAM, a, 1'b1, d);
      do_op(flash_host_pkg::OP_READ, a, 1'b1, d);
    end
    do_op(flash_host_pkg::OP_ID_ENTRY, a, 1'b0, 8'h00);
    do_op(flash_host_pkg::OP_READ, 19'h00000, 1'b1, MAKER);
    do_op(flash_host_pkg::OP_READ, 19'h00001, 1'b1, PART);
    do_op(flash_host_pkg::OP_ID_EXIT_SHORT, a, 1'b0, 8'h00);
    do_op(flash_host_pkg::OP_READ, a, 1'b1, d);
    do_op(flash_host_pkg::OP_SECTOR_ERASE, a, 1'b1, 8'hFF);
    check({1'b0, flash.sect_q}, {1'b0, a[AW-1:12]});
    do_op(flash_host_pkg::OP_READ, a, 1'b1, 8'hFF);
    do_op(flash_host_pkg::OP_PROGRAM, a, 1'b1, d);
    do_op(flash_host_pkg::OP_CHIP_ERASE, a, 1'b1, 8'hFF);
    do_op(flash_host_pkg::OP_READ, a, 1'b1, 8'hFF);
    do_op(flash_host_pkg::OP_ID_ENTRY, a, 1'b0, 8'h00);
    do_op(flash_host_pkg::OP_ID_EXIT_LONG, a, 1'b0, 8'h00);
    do_op(flash_host_pkg::OP_READ, 19'h00001, 1'b1, 8'hFF);
    check({7'h00, resp_timeout}, 8'h00);
    stuck = 1'b1;
    do_op(flash_host_pkg::OP_PROGRAM, a, 1'b0, 8'h00);
    check({7'h00, resp_timeout}, 8'h01);
    repeat (2) @(posedge clk);
    check(8'(expq.size()), 8'h00);
    test_done();
  end
endmodule // tb_top
